// ==== src/btcc_cfg.svh ====
// timing counts, widths and encodings for the trace capture controller
`ifndef BTCC_CFG_SVH
`define BTCC_CFG_SVH
`define BTCC_NUM_CHAN 4
`define BTCC_NUM_EVT 8
`define BTCC_ADDR_W 24
`define BTCC_DLY_W 16
`define BTCC_DLY_MIN 16'h0001
`define BTCC_DLY_MAX 16'hffff
`define BTCC_DEPTH 32768
`define BTCC_IDX_W 16
`endif

// ==== src/btcc_chan.sv ====
// one range-trace channel: decides whether it selects the current cycle
`timescale 1ns/1ps
module btcc_chan
  import btcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run_start,
  input wire logic i_free,
  input btcc_chan_cfg_s i_cfg,
  input btcc_cycle_s i_cyc,
  output logic o_sel,
  output logic o_used
);
  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic open;
    logic spent;
  } btcc_chan_st_s;

  btcc_chan_st_s st_r;
  btcc_chan_st_s st_nxt;
  logic start_hit;
  logic stop_hit;

  // single address compare, never a range, in window mode
  always_comb begin
    start_hit = 1'b0;
    stop_hit = 1'b0;
    if (i_cfg.mode == BTCC_MODE_WINDOW) begin
      start_hit = i_cyc.addr == i_cfg.start_addr;
      stop_hit = i_cyc.addr == i_cfg.stop_addr;
    end else if (i_cfg.mode == BTCC_MODE_EVENT) begin
      start_hit = i_cyc.evt[i_cfg.start_evt];
      stop_hit = i_cyc.evt[i_cfg.stop_evt];
    end
  end

  // open/close sequence; spent blocks restart unless cyclic
  always_comb begin
    st_nxt = st_r;
    o_sel = 1'b0;
    if (i_run_start) begin
      st_nxt = '0;
    end else if (i_cyc.valid && !i_free) begin
      case (i_cfg.mode)
        BTCC_MODE_FILTER: begin
          o_sel = i_cyc.evt[i_cfg.start_evt];
        end
        BTCC_MODE_WINDOW, BTCC_MODE_EVENT: begin
          // the stop cycle itself is still recorded
          if (!st_r.open && start_hit && !st_r.spent) begin
            st_nxt.open = 1'b1;
            o_sel = 1'b1;
          end else if (st_r.open) begin
            o_sel = 1'b1;
            if (stop_hit) begin
              st_nxt.open = 1'b0;
              st_nxt.spent = !i_cfg.cyclic;
            end
          end
        end
        default: begin
          o_sel = 1'b0;
        end
      endcase
    end
  end

  assign o_used = !i_free && (i_cfg.mode != BTCC_MODE_OFF);

  // channel register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : btcc_chan

// ==== src/btcc_pkg.sv ====
// types shared by the trace capture controller
`include "btcc_cfg.svh"
package btcc_pkg;
  typedef enum logic [1:0] {
    BTCC_MODE_OFF,
    BTCC_MODE_WINDOW,
    BTCC_MODE_FILTER,
    BTCC_MODE_EVENT
  } btcc_mode_e;

  // one range-trace channel setup
  typedef struct packed {
    btcc_mode_e mode;
    logic cyclic;
    logic [`BTCC_ADDR_W-1:0] start_addr;
    logic [`BTCC_ADDR_W-1:0] stop_addr;
    logic [$clog2(`BTCC_NUM_EVT)-1:0] start_evt;
    logic [$clog2(`BTCC_NUM_EVT)-1:0] stop_evt;
  } btcc_chan_cfg_s;

  // one observed bus cycle
  typedef struct packed {
    logic valid;
    logic [`BTCC_ADDR_W-1:0] addr;
    logic [`BTCC_NUM_EVT-1:0] evt;
  } btcc_cycle_s;

  typedef enum logic [1:0] {
    BTCC_IDLE,
    BTCC_RUN,
    BTCC_DELAY,
    BTCC_HALT
  } btcc_acq_e;
endpackage : btcc_pkg

// ==== src/btcc_top.sv ====
// trace acquisition controller: selects bus cycles into the trace buffer
//
// Overview of operation
// - delayed stop runs on for count more bus cycles, halts
// - immediate stop outranks a delayed stop in the same cycle
// - stop events act only while enabled
// - four channels; all idle in continuous capture
// - window mode opens/closes on start/stop address
// - window triggers match one single address
// - cyclic option re-arms after each stop
// - filter mode records matching cycles, plus stop trigger cycles
// - event mode opens/closes on selected events
// - continuous capture records every cycle while running
// - full buffer overwrites oldest record
// - stop record is index zero, delay counts up
//
// one bus cycle slot per clock; a record shows one clock after the
// cycle that it stores. the buffer memory sits outside: this block
// only hands out the slot, the bus address and the record index.
// stop and trigger cycles are always kept, so a stop never loses
// the cycle that caused it.
`timescale 1ns/1ps
`include "btcc_cfg.svh"
module btcc_top
  import btcc_pkg::*;
#(
  parameter int NUM_CHAN = `BTCC_NUM_CHAN,
  parameter int DEPTH = `BTCC_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_RUN_START,
  input wire logic i_RUN_HALT,
  input wire logic i_FREE,
  input wire logic i_STOP_EN,
  input wire logic [`BTCC_NUM_EVT-1:0] i_STOP_EVTS,
  input wire logic i_DSTOP_EN,
  input wire logic [`BTCC_NUM_EVT-1:0] i_DSTOP_EVTS,
  input wire logic [`BTCC_DLY_W-1:0] i_DSTOP_COUNT,
  input btcc_chan_cfg_s [NUM_CHAN-1:0] i_CHAN_CFG,
  input btcc_cycle_s i_CYC,
  output logic o_WR,
  output logic [$clog2(DEPTH)-1:0] o_WR_ADDR,
  output logic [`BTCC_ADDR_W-1:0] o_WR_BUS_ADDR,
  output logic o_WRAPPED,
  output logic o_ACTIVE,
  output logic o_STOPPED,
  output logic o_IN_DELAY,
  output logic [`BTCC_IDX_W-1:0] o_RECORD_INDEX
);
  // slot number width follows the buffer depth
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    btcc_acq_e acq;
    logic [`BTCC_DLY_W-1:0] dly;
    logic wr;
    logic [AW-1:0] wptr;
    logic [AW-1:0] waddr; // slot of the record on o_WR
    logic [`BTCC_ADDR_W-1:0] bus_addr;
    logic wrapped;
    logic [`BTCC_IDX_W-1:0] rec_idx;
    logic active; // status kept in flops, not decoded at the pins
    logic stopped;
    logic in_delay;
  } btcc_top_st_s;

  btcc_top_st_s st_r;
  btcc_top_st_s st_nxt;
  logic [NUM_CHAN-1:0] ch_sel;
  logic [NUM_CHAN-1:0] ch_used;
  // channel votes and trigger decode
  logic sel;
  logic stop_now;
  logic dstop_hit;

  // qualified cycle and counter end points
  logic acquiring;
  logic take;
  logic store;
  logic slot_last;
  logic dly_last;
  logic [`BTCC_DLY_W-1:0] dly_load;

  // ----------------------------------------------------------------
  // range channels
  // ----------------------------------------------------------------
  // channels vote per cycle; any one selecting keeps the cycle
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    btcc_chan u_chan (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_run_start(i_RUN_START),
      .i_free(i_FREE),
      .i_cfg(i_CHAN_CFG[g]),
      .i_cyc(i_CYC),
      .o_sel(ch_sel[g]),
      .o_used(ch_used[g])
    );
  end

  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  // no channel in use behaves like continuous capture
  assign sel = i_FREE || (ch_used == '0) || (|ch_sel);
  // a stop selection with its enable cleared is ignored
  assign stop_now = i_STOP_EN && |(i_STOP_EVTS & i_CYC.evt);
  assign dstop_hit = i_DSTOP_EN && |(i_DSTOP_EVTS & i_CYC.evt);

  // ----------------------------------------------------------------
  // cycle qualification
  // ----------------------------------------------------------------
  // a bus cycle only counts while recording or in the delay
  assign acquiring = (st_r.acq == BTCC_RUN) || (st_r.acq == BTCC_DELAY);
  // start and halt outrank a bus cycle in the same slot
  assign take = i_CYC.valid && acquiring && !i_RUN_START && !i_RUN_HALT;
  // trigger cycles are kept even when no channel selects them
  assign store = take && (sel || stop_now || dstop_hit);

  // ----------------------------------------------------------------
  // counter end points
  // ----------------------------------------------------------------
  // pointer wraps after the last slot; the oldest record goes next
  assign slot_last = st_r.wptr == AW'(DEPTH - 1);
  // the last delay cycle is the one that sees the minimum count
  assign dly_last = st_r.dly == `BTCC_DLY_MIN;
  // count of 0 is out of range; treated as the minimum of one
  assign dly_load = (i_DSTOP_COUNT == '0) ? `BTCC_DLY_MIN : i_DSTOP_COUNT;

  // ----------------------------------------------------------------
  // acquisition sequence
  // ----------------------------------------------------------------
  // immediate stop outranks the delayed one when both match
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr = 1'b0;
    // a program start clears the pointer and re-arms every channel
    if (i_RUN_START) begin
      st_nxt.acq = BTCC_RUN;
      st_nxt.wptr = '0;
      st_nxt.wrapped = 1'b0;
      st_nxt.rec_idx = '0;
    end else if (i_RUN_HALT) begin
      // a program halt ends acquisition; the wrap flag is kept
      st_nxt.acq = BTCC_IDLE;
    end else if (i_CYC.valid) begin
      case (st_r.acq)
        BTCC_RUN, BTCC_DELAY: begin
          // trigger cycle itself is stored in both cases
          if (store) begin
            st_nxt.wr = 1'b1;
            st_nxt.waddr = st_r.wptr;
            st_nxt.bus_addr = i_CYC.addr;
            st_nxt.wptr = st_r.wptr + 1'b1;
            if (slot_last) begin
              st_nxt.wrapped = 1'b1;
            end
          end
          // immediate stop first, then a running delay
          if (stop_now) begin
            st_nxt.acq = BTCC_HALT;
          end else if (st_r.acq == BTCC_DELAY) begin
            st_nxt.dly = st_r.dly - 1'b1;
            st_nxt.rec_idx = st_r.rec_idx + 1'b1;
            if (dly_last) begin
              st_nxt.acq = BTCC_HALT;
            end
          end else if (dstop_hit) begin
            st_nxt.acq = BTCC_DELAY;
            st_nxt.rec_idx = '0;
            st_nxt.dly = dly_load;
          end
        end
        BTCC_HALT: begin
          st_nxt.acq = BTCC_HALT;
        end
        // an idle controller waits for the next program start
        BTCC_IDLE: begin
          st_nxt.acq = BTCC_IDLE;
        end
        default: begin
          st_nxt.acq = st_r.acq;
        end
      endcase
    end

    // status flags come from the next state so the pins leave flops
    st_nxt.active = (st_nxt.acq == BTCC_RUN) ||
                    (st_nxt.acq == BTCC_DELAY);
    st_nxt.stopped = st_nxt.acq == BTCC_HALT;
    st_nxt.in_delay = st_nxt.acq == BTCC_DELAY;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // async clear puts every output at its idle level
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_r <= '{acq: BTCC_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // plain copies of state bits; no decode between flop and pin
  always_comb begin
    o_WR = st_r.wr;
    o_WR_ADDR = st_r.waddr;
    o_WR_BUS_ADDR = st_r.bus_addr;
    o_WRAPPED = st_r.wrapped;
    o_ACTIVE = st_r.active;
    o_STOPPED = st_r.stopped;
    o_IN_DELAY = st_r.in_delay;
    o_RECORD_INDEX = st_r.rec_idx;
  end
endmodule : btcc_top

// ==== test/btcc_bus_model.sv ====
// traced bus model: one cycle slot per clock
`timescale 1ns/1ps
module btcc_bus_model
  import btcc_pkg::*;
(
  input wire logic i_clk,
  output btcc_cycle_s o_cyc
);
  initial o_cyc = '0;
  task automatic send(input logic [23:0] a, logic [7:0] e);
    @(negedge i_clk);
    o_cyc = '{1'b1, a, e};
  endtask : send
  // released bus shows inverted lines so no stale cycle looks live
  task automatic idle();
    @(negedge i_clk);
    o_cyc = '{1'b0, ~o_cyc.addr, ~o_cyc.evt};
  endtask : idle
endmodule : btcc_bus_model

// ==== test/btcc_top_properties.sv ====
// port checker for the trace capture controller
`timescale 1ns/1ps
module btcc_top_chk
  import btcc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_RUN_START,
  input wire logic i_RUN_HALT,
  input wire logic i_FREE,
  input wire logic i_STOP_EN,
  input wire logic [7:0] i_STOP_EVTS,
  input wire logic i_DSTOP_EN,
  input btcc_cycle_s i_CYC,
  input wire logic o_WR,
  input wire logic [23:0] o_WR_BUS_ADDR,
  input wire logic o_ACTIVE,
  input wire logic o_STOPPED,
  input wire logic o_IN_DELAY,
  input wire logic [15:0] o_RECORD_INDEX
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // cycle taken this edge; start and halt outrank it
  logic tk;
  assign tk = i_CYC.valid && o_ACTIVE && !i_RUN_HALT && !i_RUN_START;
  property p_free;
    tk && i_FREE |=> o_WR && o_WR_BUS_ADDR == $past(i_CYC.addr);
  endproperty
  a_free: assert property (p_free) else $error("missed");
  property p_idle; !o_ACTIVE |=> !o_WR; endproperty
  a_idle: assert property (p_idle) else $error("idle wr");
  property p_stop;
    tk && i_STOP_EN && |(i_STOP_EVTS & i_CYC.evt) |=> o_STOPPED && !o_ACTIVE;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_keep;
    tk && i_FREE && !i_STOP_EN && !i_DSTOP_EN && !o_IN_DELAY |=> o_ACTIVE;
  endproperty
  a_keep: assert property (p_keep) else $error("bad stop");
  property p_zero; $rose(o_IN_DELAY) |-> o_RECORD_INDEX == 16'h0; endproperty
  a_zero: assert property (p_zero) else $error("idx");
  property p_step;
    tk && o_IN_DELAY && !i_STOP_EN |=>
      o_RECORD_INDEX == $past(o_RECORD_INDEX) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_run; i_RUN_START |=> o_ACTIVE && !o_STOPPED; endproperty
  a_run: assert property (p_run) else $error("run");
  property p_halt; i_RUN_HALT && !i_RUN_START |=> !o_ACTIVE ##1 !o_WR;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  cover property (o_WR);
  cover property ($rose(o_STOPPED));
  cover property ($rose(o_IN_DELAY));
endmodule : btcc_top_chk
bind btcc_top btcc_top_chk u_btcc_top_chk (.*);

// ==== test/test_btcc_top.sv ====
// bench: bus cycles and setups in, record writes checked
`timescale 1ns/1ps
module test_btcc_top;
  import btcc_pkg::*;
  localparam btcc_chan_cfg_s WIN = '{BTCC_MODE_WINDOW, 1'b0, 24'h400,
    24'h500, 3'h0, 3'h0};
  localparam btcc_chan_cfg_s EVC = '{BTCC_MODE_EVENT, 1'b1, 24'h0, 24'h0,
    3'h1, 3'h2};
  localparam btcc_chan_cfg_s FLT = '{BTCC_MODE_FILTER, 1'b0, 24'h0, 24'h0,
    3'h3, 3'h0};
  logic I_CLK = '0, I_RST = '1, run = '0, halt = '0, free = '0;
  logic wr, stp, dly, wrp;
  logic [1:0] st = '0;
  logic [15:0] idx;
  logic [23:0] wa;
  logic [1:0] wad;
  btcc_chan_cfg_s [3:0] cfg = '0;
  btcc_cycle_s cyc;
  int error_cnt = 0, tests_run = 0, ticks = 0, tn = 0;
  // small depth so the wrap shows in a few cycles
  btcc_top #(.DEPTH(4)) u_btcc_top (.I_CLK(I_CLK), .I_RST(I_RST),
    .i_RUN_START(run), .i_RUN_HALT(halt), .i_FREE(free),
    .i_STOP_EN(st[1]), .i_STOP_EVTS(8'h20), .i_DSTOP_EN(st[0]),
    .i_DSTOP_EVTS(8'h01), .i_DSTOP_COUNT(16'h2), .i_CHAN_CFG(cfg),
    .i_CYC(cyc), .o_WR(wr), .o_WR_ADDR(wad), .o_WR_BUS_ADDR(wa),
    .o_WRAPPED(wrp), .o_ACTIVE(), .o_STOPPED(stp), .o_IN_DELAY(dly),
    .o_RECORD_INDEX(idx));
  btcc_bus_model u_btcc_bus_model (.i_clk(I_CLK), .o_cyc(cyc));
  initial forever #2 I_CLK = ~I_CLK;
  // run needs some 40 cycles; ceiling cuts a hang
  always @(posedge I_CLK) begin
    ticks <= ticks + 1;
    if (ticks == 1000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [23:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // record of a taken cycle shows one clock later
  task automatic go(input logic [23:0] a, logic [7:0] e, logic w);
    u_btcc_bus_model.send(a, e);
    @(posedge I_CLK);
    #1;
    chk({23'h0, wr}, {23'h0, w});
    if (w) chk(wa, a);
  endtask : go
  // bus released, setup on a new channel each test, program started
  task automatic next(input logic f, logic [1:0] s, btcc_chan_cfg_s c);
    u_btcc_bus_model.idle();
    if (tn > 0) $display("test %0d done", tn);
    tn++;
    free = f;
    st = s;
    cfg = c << ($bits(btcc_chan_cfg_s) * tn[1:0]);
    run = 1;
    @(negedge I_CLK);
    run = 0;
  endtask : next
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(negedge I_CLK);
    I_RST = 0;
    next(1, 2'h0, WIN);
    for (int i = 0; i < 5; i++) begin
      go(24'h100 + 24'(i), 8'h0, 1);
      chk({22'h0, wad}, 24'(i % 4));
    end
    @(negedge I_CLK);
    halt = 1;
    @(negedge I_CLK);
    halt = 0;
    chk({23'h0, wrp}, 24'h1);
    go(24'h200, 8'h0, 0);
    next(0, 2'h0, WIN);
    go(24'h401, 8'h0, 0);
    go(24'h400, 8'h0, 1);
    go(24'h500, 8'h0, 1);
    go(24'h450, 8'h0, 0);
    go(24'h400, 8'h0, 0);
    next(0, 2'h0, EVC);
    go(24'h10, 8'h0, 0);
    go(24'h11, 8'h02, 1);
    go(24'h12, 8'h04, 1);
    go(24'h13, 8'h0, 0);
    go(24'h14, 8'h02, 1);
    next(0, 2'h0, FLT);
    go(24'h20, 8'h08, 1);
    go(24'h21, 8'h04, 0);
    next(1, 2'h1, '0);
    go(24'h30, 8'h20, 1);
    go(24'h31, 8'h01, 1);
    chk({8'h0, idx}, 24'h0);
    go(24'h32, 8'h0, 1);
    go(24'h33, 8'h0, 1);
    chk({7'h0, stp, idx}, 24'h10002);
    go(24'h34, 8'h0, 0);
    next(1, 2'h3, '0);
    go(24'h40, 8'h01, 1);
    go(24'h41, 8'h20, 1);
    chk({22'h0, dly, stp}, 24'h1);
    go(24'h42, 8'h0, 0);
    $display("test %0d done", tn);
    stop_test();
  end
endmodule : test_btcc_top
